// File: src/oms_device.sv
// Operating mode sequencer: metering device end.
// Assumes powerGood and supplyLow are analog levels; currentDetect
// comes from logic on clk.
//
// Summary of operation
// - After reset set ADC input byte all ones
// - Then set scaler bits to 101 automatically
// - Ignore mode pins for 488us after that
// - Decode mode pins into four modes
// - Deep-sleep pin high forces deep sleep
// - Normal mode runs full clocks, all digital
// - Host writes non-analog registers only in normal
// - Select 10 gives reduced normal clock rates
// - Metering select 11 gives lowest rate
// - Pre-detection: host interface not reliable
// - Enabled current detect sets flag, raises pin
// - Reduced pre-detection settles within 20ms
// - Full-rate RMS mode settles within 135ms
// - RMS mode runs only its listed blocks
// - Both pins low in normal mode: slow clock, sleep later
// - Sleep keeps state; either pin wakes
// - Deep pin high over 4ms enters
// - Deep pin low over 4ms restores
// - Deep sleep cuts core supply, loses state
// - Hold reset 244us after supply good
// - Enabled supply drop sets flag bit 16
// - Sampling select scales 204.8kHz base
// - Host keeps metering at eight times sampling; oms_host does not enforce it
// - Host then writes scaler bits 110
`timescale 1ns/100ps
`default_nettype none

module oms_device
  import oms_pkg::*;
#(
  parameter int PIN_WAIT   = oms_pkg::PIN_WAIT_CYC,
  parameter int POR_HOLD   = oms_pkg::POR_HOLD_CYC,
  parameter int DEEP_HOLD  = oms_pkg::DEEP_HOLD_CYC,
  parameter int SETTLE_PRE = oms_pkg::SETTLE_PRE_CYC,
  parameter int SETTLE_RMS = oms_pkg::SETTLE_RMS_CYC
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  // Link to host
  oms_link_if.device        link,
  // Analog status
  input  wire logic         powerGood,
  input  wire logic         supplyLow,
  input  wire logic [2:0]   currentDetect,
  // Mode and clock control
  output var  oms_pkg::oms_mode_t opMode,
  output var  logic         sysClockSlow,
  output var  logic         coreSupplyOn,
  output var  logic [7:0]   adcInputsOn,
  output var  logic [2:0]   scalerSetting,
  output var  logic [3:0]   samplingMult,
  output var  logic [3:0]   meteringMult,
  // Block run enables
  output var  logic         fullDigitalRun,
  output var  logic         meteringRun,
  output var  logic         currentPathRun,
  output var  logic         hostIfReliable,
  output var  logic         modeSettled
);
  import oms_pkg::*;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic oms_mode_t decodeMode(input logic p0, input logic p1);
    case ({p0, p1})
      2'b11:   decodeMode = NORMAL_MODE;
      2'b10:   decodeMode = PREDETECT_MODE;
      2'b01:   decodeMode = RMS_ONLY_MODE;
      default: decodeMode = SLEEP_MODE;
    endcase
  endfunction

  // Multipliers of the 204.8 kHz sampling base
  function automatic logic [3:0] sampMul(input logic [1:0] sel);
    case (sel)
      2'b00:   sampMul = 4'h4;
      2'b01:   sampMul = 4'h8;
      2'b10:   sampMul = 4'h1;
      default: sampMul = 4'h2;
    endcase
  endfunction

  // Multipliers of the 819.2 kHz metering base
  function automatic logic [3:0] mtrMul(input logic [1:0] sel);
    case (sel)
      2'b00:   mtrMul = 4'h8;
      2'b01:   mtrMul = 4'h4;
      2'b10:   mtrMul = 4'h2;
      default: mtrMul = 4'h1;
    endcase
  endfunction

  // ------------------------------------------------------------------
  // Input conditioning
  // ------------------------------------------------------------------
  logic pm0, pm1, deepHeld;
  logic pgMeta_r, pgSync_r, lowMeta_r, lowSync_r;

  oms_pin_filter #(.HOLD_CYC(MODE_PIN_HOLD_CYC), .CNT_W(2),
                   .RESET_LEVEL(1'b0)) u_pm0 (
    .clk(clk), .reset(reset), .pinRaw(link.modePinZero), .pinLevel(pm0));
  oms_pin_filter #(.HOLD_CYC(MODE_PIN_HOLD_CYC), .CNT_W(2),
                   .RESET_LEVEL(1'b0)) u_pm1 (
    .clk(clk), .reset(reset), .pinRaw(link.modePinOne), .pinLevel(pm1));
  // Strictly longer than the hold time, hence one extra cycle
  oms_pin_filter #(.HOLD_CYC(DEEP_HOLD + 1), .CNT_W(18),
                   .RESET_LEVEL(1'b0)) u_deep (
    .clk(clk), .reset(reset), .pinRaw(link.deepSleepPin),
    .pinLevel(deepHeld));

  always_ff @(posedge clk)
  begin
    pgMeta_r  <= powerGood;
    pgSync_r  <= pgMeta_r;
    lowMeta_r <= supplyLow;
    lowSync_r <= lowMeta_r;
  end

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  oms_state_t  state_r;
  logic [15:0] cnt_r;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_r <= ST_POR_HOLD;
      opMode  <= NORMAL_MODE;
      cnt_r   <= '0;
    end
    else if (deepHeld && state_r != ST_DEEP)
    begin
      state_r <= ST_DEEP;
      opMode  <= DEEP_SLEEP_MODE;
    end
    else
    begin
      case (state_r)
        ST_POR_HOLD:
          if (!pgSync_r)
            cnt_r <= '0;
          else if (cnt_r == 16'(POR_HOLD - 1))
          begin
            state_r <= ST_AUTO_ADC;
            cnt_r   <= '0;
          end
          else
            cnt_r <= cnt_r + 1'b1;
        ST_AUTO_ADC:
          state_r <= ST_AUTO_SCALER;
        ST_AUTO_SCALER:
          state_r <= ST_PIN_WAIT;
        ST_PIN_WAIT:
          if (cnt_r == 16'(PIN_WAIT - 1))
          begin
            state_r <= ST_RUN;
            opMode  <= decodeMode(pm0, pm1);
            cnt_r   <= '0;
          end
          else
            cnt_r <= cnt_r + 1'b1;
        ST_RUN:
          if (!pm0 && !pm1)
          begin
            // Sleep is entered from normal mode only
            if (opMode == NORMAL_MODE)
              state_r <= ST_SLEEP_ENTRY;
          end
          else
            opMode <= decodeMode(pm0, pm1);
        ST_SLEEP_ENTRY:
          if (cnt_r == 16'(PIN_WAIT - 1))
          begin
            state_r <= ST_SLEEP;
            opMode  <= SLEEP_MODE;
            cnt_r   <= '0;
          end
          else
            cnt_r <= cnt_r + 1'b1;
        ST_SLEEP:
          if (pm0 || pm1)
          begin
            state_r <= ST_RUN;
            opMode  <= decodeMode(pm0, pm1);
          end
        ST_DEEP:
          if (!deepHeld)
          begin
            // Core was unpowered: restart as from power-on
            state_r <= ST_POR_HOLD;
            opMode  <= NORMAL_MODE;
            cnt_r   <= '0;
          end
        default:
          state_r <= ST_POR_HOLD;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  logic [31:0] anaTwo_r, anaThree_r, irqEnA_r, irqEnB_r, irqFlags_r;
  logic        wrOk, wrAna;
  logic [31:0] irqSet;

  assign wrAna = link.regAddr == ANA_TWO_ADDR
              || link.regAddr == ANA_THREE_ADDR;
  // Other registers only take writes in normal mode
  assign wrOk  = link.regWr && state_r == ST_RUN
              && (wrAna || opMode == NORMAL_MODE);

  always_ff @(posedge clk)
  begin
    if (reset || state_r == ST_DEEP)
    begin
      anaTwo_r   <= REG_RESET;
      anaThree_r <= REG_RESET;
      irqEnA_r   <= REG_RESET;
      irqEnB_r   <= REG_RESET;
    end
    else if (state_r == ST_AUTO_ADC)
      anaTwo_r[ADC_IN_LSB +: 8] <= ADC_IN_ALL_ON;
    else if (state_r == ST_AUTO_SCALER)
      anaThree_r[SCALER_LSB +: 3] <= SCALER_AUTO;
    else if (wrOk)
      case (link.regAddr)
        ANA_TWO_ADDR:   anaTwo_r   <= link.regWrData;
        ANA_THREE_ADDR: anaThree_r <= link.regWrData;
        IRQ_EN_A_ADDR:  irqEnA_r   <= link.regWrData;
        IRQ_EN_B_ADDR:  irqEnB_r   <= link.regWrData;
        default:        ;
      endcase
  end

  always_comb
  begin
    irqSet = '0;
    irqSet[IRQ_CUR_LSB +: 3] = currentDetect & {3{currentPathRun}}
      & (irqEnA_r[IRQ_CUR_LSB +: 3] | irqEnB_r[IRQ_CUR_LSB +: 3]);
    irqSet[IRQ_PD_BIT] = lowSync_r
      & (irqEnA_r[IRQ_PD_BIT] | irqEnB_r[IRQ_PD_BIT]);
  end

  // Write one to clear; a new event wins over the clear
  always_ff @(posedge clk)
  begin
    if (reset || state_r == ST_DEEP)
      irqFlags_r <= REG_RESET;
    else if (wrOk && link.regAddr == IRQ_FLAGS_ADDR)
      irqFlags_r <= (irqFlags_r & ~link.regWrData) | irqSet;
    else
      irqFlags_r <= irqFlags_r | irqSet;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      link.irqPinA   <= 1'b0;
      link.irqPinB   <= 1'b0;
      link.regRdData <= '0;
    end
    else
    begin
      link.irqPinA <= |(irqFlags_r & irqEnA_r);
      link.irqPinB <= |(irqFlags_r & irqEnB_r);
      if (link.regRd)
        case (link.regAddr)
          ANA_TWO_ADDR:   link.regRdData <= anaTwo_r;
          ANA_THREE_ADDR: link.regRdData <= anaThree_r;
          IRQ_EN_A_ADDR:  link.regRdData <= irqEnA_r;
          IRQ_EN_B_ADDR:  link.regRdData <= irqEnB_r;
          IRQ_FLAGS_ADDR: link.regRdData <= irqFlags_r;
          default:        link.regRdData <= '0;
        endcase
      else
        link.regRdData <= '0;
    end
  end

  // ------------------------------------------------------------------
  // Clock and block control
  // ------------------------------------------------------------------
  logic running, slowing;
  assign running = state_r == ST_RUN;
  assign slowing = state_r == ST_SLEEP_ENTRY || state_r == ST_SLEEP;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sysClockSlow   <= 1'b1;
      coreSupplyOn   <= 1'b1;
      adcInputsOn    <= '0;
      scalerSetting  <= '0;
      samplingMult   <= '0;
      meteringMult   <= '0;
      fullDigitalRun <= 1'b0;
      meteringRun    <= 1'b0;
      currentPathRun <= 1'b0;
      hostIfReliable <= 1'b0;
    end
    else
    begin
      sysClockSlow  <= slowing
                    || !anaThree_r[SCALER_EN_BIT];
      coreSupplyOn  <= state_r != ST_DEEP;
      adcInputsOn   <= slowing ? 8'h00
                    : anaTwo_r[ADC_IN_LSB +: 8];
      scalerSetting <= anaThree_r[SCALER_LSB +: 3];
      samplingMult  <= sampMul(anaThree_r[SAMP_SEL_LSB +: 2]);
      meteringMult  <= mtrMul(anaThree_r[MTR_SEL_LSB +: 2]);
      fullDigitalRun <= running && opMode == NORMAL_MODE;
      meteringRun    <= running && (opMode == NORMAL_MODE
                     || opMode == RMS_ONLY_MODE);
      currentPathRun <= running && opMode != SLEEP_MODE;
      hostIfReliable <= running
                     && opMode != PREDETECT_MODE;
    end
  end

  // ------------------------------------------------------------------
  // Settling after a mode change
  // ------------------------------------------------------------------
  oms_mode_t   lastMode_r;
  logic [22:0] settleCnt_r;
  logic [22:0] settleTarget;

  // Reduced-clock pre-detection settles faster than full-rate RMS
  assign settleTarget =
    (opMode == PREDETECT_MODE
     && anaThree_r[MTR_SEL_LSB +: 2] == MTR_SEL_LOWEST)
      ? 23'(SETTLE_PRE) : 23'(SETTLE_RMS);

  always_ff @(posedge clk)
  begin
    if (reset || !running || opMode != lastMode_r)
    begin
      lastMode_r  <= opMode;
      settleCnt_r <= '0;
      modeSettled <= 1'b0;
    end
    else if (settleCnt_r >= settleTarget - 1'b1)
      modeSettled <= 1'b1;
    else
      settleCnt_r <= settleCnt_r + 1'b1;
  end
endmodule // oms_device

`default_nettype wire

// File: src/oms_pkg.sv
// Shared constants and types of the operating mode sequencer.
// Assumes a single 40 MHz clock and a synchronous active-high reset.
package oms_pkg;

  // ------------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 25;
  localparam int PIN_WAIT_US    = 488;
  localparam int POR_HOLD_US    = 244;
  localparam int DEEP_HOLD_MS   = 4;
  localparam int SETTLE_PRE_MS  = 20;
  localparam int SETTLE_RMS_MS  = 135;
  // Least times round up, longest times round down
  localparam int PIN_WAIT_CYC   =
    (PIN_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POR_HOLD_CYC   =
    (POR_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEEP_HOLD_CYC  =
    (DEEP_HOLD_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_PRE_CYC = (SETTLE_PRE_MS * 1000000) / CLK_PERIOD_NS;
  localparam int SETTLE_RMS_CYC = (SETTLE_RMS_MS * 1000000) / CLK_PERIOD_NS;
  localparam int MODE_PIN_HOLD_CYC = 2;

  // ------------------------------------------------------------------
  // Device register map and fields
  // ------------------------------------------------------------------
  localparam logic [15:0] ANA_TWO_ADDR   = 16'h8002;
  localparam logic [15:0] ANA_THREE_ADDR = 16'h8003;
  localparam logic [15:0] IRQ_EN_A_ADDR  = 16'hA000;
  localparam logic [15:0] IRQ_EN_B_ADDR  = 16'hA001;
  localparam logic [15:0] IRQ_FLAGS_ADDR = 16'hA002;
  localparam logic [31:0] REG_RESET      = 32'h0000_0000;
  localparam int          ADC_IN_LSB     = 24;
  localparam logic [7:0]  ADC_IN_ALL_ON  = 8'hFF;
  localparam int          SCALER_LSB     = 0;
  localparam logic [2:0]  SCALER_AUTO    = 3'h5;
  localparam int          SCALER_EN_BIT  = 2;
  localparam int          SAMP_SEL_LSB   = 18;
  localparam int          MTR_SEL_LSB    = 16;
  localparam logic [1:0]  MTR_SEL_LOWEST = 2'h3;
  localparam int          IRQ_CUR_LSB    = 11;
  localparam int          IRQ_PD_BIT     = 16;

  // ------------------------------------------------------------------
  // Host controller register map
  // ------------------------------------------------------------------
  localparam logic [3:0]  HC_PINS_ADDR   = 4'h0;
  localparam logic [3:0]  HC_TADDR_ADDR  = 4'h1;
  localparam logic [3:0]  HC_TDATA_ADDR  = 4'h2;
  localparam logic [3:0]  HC_CMD_ADDR    = 4'h3;
  localparam logic [3:0]  HC_STATUS_ADDR = 4'h4;
  localparam logic [3:0]  HC_RDATA_ADDR  = 4'h5;
  localparam logic [2:0]  HC_PINS_RESET  = 3'h3;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    NORMAL_MODE     = 3'b000,
    PREDETECT_MODE  = 3'b001,
    RMS_ONLY_MODE   = 3'b010,
    SLEEP_MODE      = 3'b011,
    DEEP_SLEEP_MODE = 3'b100
  } oms_mode_t;

  typedef enum logic [2:0] {
    ST_POR_HOLD    = 3'b000,
    ST_AUTO_ADC    = 3'b001,
    ST_AUTO_SCALER = 3'b010,
    ST_PIN_WAIT    = 3'b011,
    ST_RUN         = 3'b100,
    ST_SLEEP_ENTRY = 3'b101,
    ST_SLEEP       = 3'b110,
    ST_DEEP        = 3'b111
  } oms_state_t;

endpackage

// File: src/oms_link_if.sv
// Pins and register port between host controller and metering device.
// Assumes both ends run on the same clock; mode pins are filtered
// by the device, interrupt pins are synchronised by the host.
`timescale 1ns/100ps
`default_nettype none

interface oms_link_if;
  logic        modePinZero;
  logic        modePinOne;
  logic        deepSleepPin;
  logic        irqPinA;
  logic        irqPinB;
  logic [15:0] regAddr;
  logic [31:0] regWrData;
  logic        regWr;
  logic        regRd;
  logic [31:0] regRdData;

  modport device (
    input  modePinZero, modePinOne, deepSleepPin,
    input  regAddr, regWrData, regWr, regRd,
    output irqPinA, irqPinB, regRdData
  );

  modport host (
    output modePinZero, modePinOne, deepSleepPin,
    output regAddr, regWrData, regWr, regRd,
    input  irqPinA, irqPinB, regRdData
  );
endinterface

`default_nettype wire

// File: src/oms_pin_filter.sv
// Two-flop synchroniser plus hold filter for one slow input pin.
// The filtered level follows the pin only after it has differed for
// HOLD_CYC consecutive cycles.
`timescale 1ns/100ps
`default_nettype none

module oms_pin_filter #(
  parameter int   HOLD_CYC    = 2,
  parameter int   CNT_W       = 18,
  parameter logic RESET_LEVEL = 1'b0
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Pin and filtered level
  input  wire logic pinRaw,
  output var  logic pinLevel
);
  logic             meta_r;
  logic             sync_r;
  logic [CNT_W-1:0] cnt_r;

  always_ff @(posedge clk)
  begin
    meta_r <= pinRaw;
    sync_r <= meta_r;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pinLevel <= RESET_LEVEL;
      cnt_r    <= '0;
    end
    else if (sync_r == pinLevel)
      cnt_r <= '0;
    else if (cnt_r == CNT_W'(HOLD_CYC - 1))
    begin
      pinLevel <= sync_r;
      cnt_r    <= '0;
    end
    else
      cnt_r <= cnt_r + 1'b1;
  end
endmodule // oms_pin_filter

`default_nettype wire

// File: src/oms_host.sv
// Operating mode sequencer: host controller end.
// Assumes software on a plain port with read data one cycle later.
`timescale 1ns/100ps
`default_nettype none

module oms_host
  import oms_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Link to device
  oms_link_if.host         link,
  // Software port
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wrData,
  input  wire logic        wr,
  input  wire logic        rd,
  output var  logic [31:0] rdData
);
  import oms_pkg::*;

  logic [2:0]  pins_r;
  logic [15:0] tAddr_r;
  logic [31:0] tData_r, rback_r;
  logic        refused_r, rdPend_r;
  logic [1:0]  irqMeta_r, irqSync_r;
  logic        normalSel, predetSel, anaTarget, goWr, goRd;

  // ------------------------------------------------------------------
  // Access policy
  // ------------------------------------------------------------------
  assign normalSel = pins_r == 3'b011;
  assign predetSel = pins_r == 3'b001;
  assign anaTarget = tAddr_r == ANA_TWO_ADDR
                  || tAddr_r == ANA_THREE_ADDR;
  // No access when the device link is unreliable or asleep
  assign goWr = wr && addr == HC_CMD_ADDR && wrData[0] && !pins_r[2]
             && !predetSel && pins_r[1:0] != 2'b00
             && (anaTarget || normalSel);
  assign goRd = wr && addr == HC_CMD_ADDR && wrData[1] && !wrData[0]
             && !pins_r[2] && !predetSel && pins_r[1:0] != 2'b00;

  // ------------------------------------------------------------------
  // Registers and link drive
  // ------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pins_r          <= HC_PINS_RESET;
      tAddr_r         <= '0;
      tData_r         <= '0;
      refused_r       <= 1'b0;
      link.regWr      <= 1'b0;
      link.regRd      <= 1'b0;
      link.regAddr    <= '0;
      link.regWrData  <= '0;
    end
    else
    begin
      link.regWr <= goWr;
      link.regRd <= goRd;
      if (goWr || goRd)
      begin
        link.regAddr   <= tAddr_r;
        link.regWrData <= tData_r;
      end
      if (wr && addr == HC_CMD_ADDR)
        refused_r <= (wrData[0] && !goWr) || (wrData[1] && !wrData[0]
                  && !goRd);
      if (wr && addr == HC_PINS_ADDR)
        pins_r <= wrData[2:0];
      if (wr && addr == HC_TADDR_ADDR)
        tAddr_r <= wrData[15:0];
      if (wr && addr == HC_TDATA_ADDR)
        tData_r <= wrData;
    end
  end

  // Pins come straight from the pin register flops
  assign link.modePinZero  = pins_r[0];
  assign link.modePinOne   = pins_r[1];
  assign link.deepSleepPin = pins_r[2];

  always_ff @(posedge clk)
  begin
    irqMeta_r <= {link.irqPinB, link.irqPinA};
    irqSync_r <= irqMeta_r;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rdPend_r <= 1'b0;
      rback_r  <= '0;
    end
    else
    begin
      rdPend_r <= link.regRd;
      if (rdPend_r)
        rback_r <= link.regRdData;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset || !rd)
      rdData <= '0;
    else
      case (addr)
        HC_PINS_ADDR:   rdData <= {29'h0, pins_r};
        HC_TADDR_ADDR:  rdData <= {16'h0, tAddr_r};
        HC_TDATA_ADDR:  rdData <= tData_r;
        HC_STATUS_ADDR: rdData <= {28'h0, refused_r, irqSync_r,
                                   link.regRd | rdPend_r};
        HC_RDATA_ADDR:  rdData <= rback_r;
        default:        rdData <= '0;
      endcase
  end
endmodule // oms_host

`default_nettype wire

// File: verification/oms_link_properties.sv
// Checker on the link between host end and device end.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module oms_link_properties #(
  parameter int DEEP_HOLD = 20
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // Link
  input wire logic        modePinZero,
  input wire logic        modePinOne,
  input wire logic        deepSleepPin,
  input wire logic        irqPinA,
  input wire logic        irqPinB,
  input wire logic [15:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [31:0] regRdData
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic [7:0] deepCnt;
  // Saturates so a long deep stay never wraps
  always_ff @(posedge clk)
    if (reset || !deepSleepPin)
      deepCnt <= 8'h00;
    else if (deepCnt != 8'hFF)
      deepCnt <= deepCnt + 8'h01;

  a_rd_idle: assert property (!$past(regRd) |-> regRdData == 32'h0)
    else $error("read data outside answer cycle");
  a_strobe_excl: assert property (!(regWr && regRd))
    else $error("write and read strobes together");
  a_wr_single: assert property (regWr |=> !regWr)
    else $error("write strobe longer than one cycle");
  a_rel_pins: assert property ($fell(reset) |->
    {deepSleepPin, modePinOne, modePinZero} == 3'h3)
    else $error("mode pins not normal after reset");
  a_rel_irq: assert property ($fell(reset) |-> !irqPinA && !irqPinB)
    else $error("interrupt pin high after reset");
  a_deep_quiet: assert property (int'(deepCnt) > DEEP_HOLD + 10 |->
    !irqPinA && !irqPinB && regRdData == 32'h0)
    else $error("state kept in deep sleep");
  a_irq_a_hold: assert property ($fell(irqPinA) |->
    $past(regWr, 2) || $past(regWr, 3) || deepSleepPin)
    else $error("pin A dropped without clear");
  a_irq_b_hold: assert property ($fell(irqPinB) |->
    $past(regWr, 2) || $past(regWr, 3) || deepSleepPin)
    else $error("pin B dropped without clear");

  c_read: cover property (regRd ##1 regRdData != 32'h0);
  c_irq_a: cover property ($rose(irqPinA));
  c_irq_b: cover property ($rose(irqPinB));
  c_deep: cover property (int'(deepCnt) == DEEP_HOLD + 11);
endmodule // oms_link_properties
`default_nettype wire

// File: verification/operating_mode_sequencer_tb_top.sv
// Bench joining host end and device end, driven via software port.
// Assumes shortened device counts set below.
`timescale 1ns/100ps
`default_nettype none
module operating_mode_sequencer_tb_top;
  import oms_pkg::*;
  logic        clk, reset, powerGood, supplyLow, wr, rd;
  logic        slow, coreOn, fullRun, mtrRun, curRun, hostOk, settled;
  logic [2:0]  currentDetect, scaler;
  logic [3:0]  addr, sMult, mMult;
  logic [7:0]  adcOn;
  logic [31:0] wrData, rdData, lfsr, d;
  oms_mode_t   opMode;
  int          error_cnt, n_compared, k;
  oms_link_if link();
  oms_device #(.PIN_WAIT(8), .POR_HOLD(8), .DEEP_HOLD(20), .SETTLE_PRE(30),
    .SETTLE_RMS(50)) i_oms_device (.clk(clk), .reset(reset), .link(link),
    .powerGood(powerGood), .supplyLow(supplyLow),
    .currentDetect(currentDetect), .opMode(opMode), .sysClockSlow(slow),
    .coreSupplyOn(coreOn), .adcInputsOn(adcOn), .scalerSetting(scaler),
    .samplingMult(sMult), .meteringMult(mMult), .fullDigitalRun(fullRun),
    .meteringRun(mtrRun), .currentPathRun(curRun), .hostIfReliable(hostOk),
    .modeSettled(settled));
  oms_host i_oms_host (.clk(clk), .reset(reset), .link(link), .addr(addr),
    .wrData(wrData), .wr(wr), .rd(rd), .rdData(rdData));
  oms_link_properties i_oms_link_properties (.clk(clk),
    .reset(reset), .modePinZero(link.modePinZero),
    .modePinOne(link.modePinOne), .deepSleepPin(link.deepSleepPin),
    .irqPinA(link.irqPinA), .irqPinB(link.irqPinB), .regAddr(link.regAddr),
    .regWrData(link.regWrData), .regWr(link.regWr), .regRd(link.regRd),
    .regRdData(link.regRdData));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [3:0] sampF(input logic [1:0] s);
    return (s == 2'h0) ? 4'h4 : (s == 2'h1) ? 4'h8 : (s == 2'h2) ? 4'h1 : 4'h2;
  endfunction
  function automatic oms_mode_t modeF(input logic [2:0] p);
    return p[2] ? DEEP_SLEEP_MODE : (p == 3'h3) ? NORMAL_MODE :
      (p == 3'h1) ? PREDETECT_MODE : (p == 3'h2) ? RMS_ONLY_MODE : SLEEP_MODE;
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input string nm, input logic [63:0] e, g);
    n_compared++;
    if (e !== g)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic sw(input logic [3:0] a, input logic [31:0] v);
    addr <= a;
    wrData <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic srd(input logic [3:0] a, output logic [31:0] v);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    v = rdData;
  endtask
  task automatic dw(input logic [15:0] a, input logic [31:0] v);
    sw(HC_TADDR_ADDR, {16'h0, a});
    sw(HC_TDATA_ADDR, v);
    sw(HC_CMD_ADDR, 32'h1);
    cyc(3);
  endtask
  task automatic dr(input logic [15:0] a, output logic [31:0] v);
    sw(HC_TADDR_ADDR, {16'h0, a});
    sw(HC_CMD_ADDR, 32'h2);
    cyc(4);
    srd(HC_RDATA_ADDR, v);
  endtask
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Guard against a hung sequence
  initial
  begin
    cyc(5000);
    error_cnt++;
    summarize();
  end

  initial
  begin
    reset = 1'b1; powerGood = 1'b0; supplyLow = 1'b0; currentDetect = 3'h0;
    addr = 4'h0; wrData = 32'h0; wr = 1'b0; rd = 1'b0; lfsr = 32'h7299;
    cyc(16);
    reset <= 1'b0;
    sw(HC_PINS_ADDR, 32'h1);
    cyc(16);
    chk("early", {NORMAL_MODE, 8'h00}, {opMode, adcOn});
    powerGood <= 1'b1;
    cyc(40);
    chk("adc inputs", 8'hFF, adcOn);
    chk("late mode", PREDETECT_MODE, opMode);
    chk("host if", 1'b0, hostOk);
    chk("unsettled", 1'b0, settled);
    for (k = 1; k <= 3; k++)
    begin
      sw(HC_PINS_ADDR, k);
      cyc(8);
      chk("mode", modeF(k[2:0]), opMode);
      chk("metering run", k != 1, mtrRun);
      chk("full run", {k == 3, 1'b1}, {fullRun, curRun});
    end
    dr(ANA_THREE_ADDR, d);
    chk("auto scaler", SCALER_AUTO, d[2:0]);
    sw(HC_PINS_ADDR, 32'h2);
    cyc(6);
    dw(IRQ_EN_A_ADDR, 32'h3800);
    srd(HC_STATUS_ADDR, d);
    chk("refused", 1'b1, d[3]);
    for (k = 0; k < 4; k++)
    begin
      lfsr = nx(lfsr);
      dw(ANA_THREE_ADDR, {12'h0, k[1:0], lfsr[1:0], 16'h6});
      chk("samp mult", sampF(k[1:0]), sMult);
      chk("mtr mult", 4'h8 >> lfsr[1:0], mMult);
      chk("scaler", 3'h6, scaler);
    end
    dw(ANA_THREE_ADDR, 32'h6);
    sw(HC_PINS_ADDR, 32'h3);
    cyc(6);
    dw(IRQ_EN_A_ADDR, 32'h3800);
    lfsr = nx(lfsr);
    currentDetect <= 3'h1 << (lfsr % 3);
    cyc(1);
    currentDetect <= 3'h0;
    cyc(4);
    chk("irq a", 1'b1, link.irqPinA);
    dr(IRQ_FLAGS_ADDR, d);
    chk("cur flags", 3'h1 << (lfsr % 3), d[13:11]);
    dw(IRQ_FLAGS_ADDR, 32'h3800);
    chk("irq a clr", 1'b0, link.irqPinA);
    dw(IRQ_EN_B_ADDR, 32'h1_0000);
    supplyLow <= 1'b1;
    cyc(6);
    srd(HC_STATUS_ADDR, d);
    chk("irq b", 1'b1, d[2]);
    supplyLow <= 1'b0;
    dw(IRQ_FLAGS_ADDR, 32'h1_0000);
    chk("irq b clr", 1'b0, link.irqPinB);
    chk("settled", 1'b1, settled);
    sw(HC_PINS_ADDR, 32'h0);
    cyc(20);
    chk("sleep", {SLEEP_MODE, 9'h1}, {opMode, adcOn, slow});
    sw(HC_PINS_ADDR, 32'h3);
    cyc(8);
    dr(IRQ_EN_B_ADDR, d);
    chk("kept", {NORMAL_MODE, 32'h1_0000}, {opMode, d});
    sw(HC_PINS_ADDR, 32'h7);
    cyc(15);
    chk("deep early", NORMAL_MODE, opMode);
    cyc(15);
    chk("deep", {DEEP_SLEEP_MODE, 1'b0}, {opMode, coreOn});
    sw(HC_PINS_ADDR, 32'h3);
    cyc(10);
    chk("deep stay", DEEP_SLEEP_MODE, opMode);
    cyc(60);
    dr(IRQ_EN_B_ADDR, d);
    chk("wake", {NORMAL_MODE, 40'hFF_0000_0000}, {opMode, adcOn, d});
    summarize();
  end
endmodule // operating_mode_sequencer_tb_top
`default_nettype wire
